// ---- logic/bcdrs_top.sv ----
// Register set of a two-channel BCD instrument interface
`timescale 1ns/10ps
`include "bcdrs_defs.svh"

// Overview of operation
// - Ten register numbers, 0 to 9: read, write and bidirectional groups.
// - Reads reach read registers; writes reach write registers.
// - Reset defaults assume switch bank all zero.
// - Register 0 reads fixed identity, bit 7 zero.
// - Cause register shows enabled bits that interrupted.
// - Status bits 7,6 show channel directions.
// - Status bits 5,4 show request lines busy.
// - Status bits 3,2 show peripheral flags.
// - Status bits 1,0 read zero; default zero.
// - Write register 0 rejected with error 111.
// - Mask written by arm or plain write.
// - Only most significant function digit interrupts.
// - Output direction needs switch 8, else 113.
// - Request line held until cleared; transfers 118.
// - Low four bits drive port 10 output.
// - Port 10 unavailable write rejected with 114.
// - Mantissa digit counts persist; reset value 8.
// - After interrupt, block until mask re-armed.
// - Request line released on selected flag edge.
module bcdrs_top import bcdrs_pkg::*; #(
  // Arbitrary identity value, bit 7 forced low on read
  parameter logic [7:0] ID_VALUE = 8'h5a
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Register operations
  input wire logic op_valid_i,
  input wire bcdrs_op_type op_kind_i,
  input wire logic [3:0] op_reg_i,
  input wire logic [7:0] op_data_i,
  output logic op_ready_o,
  // Answers
  output logic ans_valid_o,
  output logic [7:0] ans_err_o,
  output logic [7:0] ans_data_o,
  input wire logic ans_ready_i,
  // Board configuration
  input wire logic [7:0] config_switch_bank_i,
  input wire logic aux_port_unavail_i,
  // Instrument side
  input wire logic flag_a_i,
  input wire logic flag_b_i,
  input wire logic func_strobe_a_i,
  input wire logic [3:0] func_msd_a_i,
  input wire logic func_strobe_b_i,
  input wire logic [3:0] func_msd_b_i,
  output logic dir_a_o,
  output logic dir_b_o,
  output logic request_line_chan_a_o,
  output logic request_line_chan_b_o,
  output logic [3:0] port10_o,
  output logic intr_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] mask_q;
  logic [7:0] cause_q;
  logic armed_q;
  logic intr_q;
  logic dir_a_q;
  logic dir_b_q;
  logic [3:0] port10_q;
  logic [7:0] bidir_q [`BCDRS_BIDIR_COUNT];

  logic take;
  logic is_read;
  logic is_write;
  logic is_arm;
  logic is_xfer;
  logic hsk_wr;
  logic mask_wr;
  logic bidir_wr;
  logic [7:0] ans_err_d;
  logic [7:0] ans_data_d;
  logic [7:0] hsk_status;
  logic [7:0] digit_vec;
  logic [7:0] hit;
  logic request_line_chan_a;
  logic request_line_chan_b;

  function automatic logic is_bidir(input logic [3:0] r);
    is_bidir = (r >= `BCDRS_REG_MANT) && (r <= `BCDRS_REG_BIDIR_LAST);
  endfunction

  function automatic logic [2:0] bidir_idx(input logic [3:0] r);
    logic [3:0] d;
    d = r - `BCDRS_REG_MANT;
    bidir_idx = d[2:0];
  endfunction

  assign take = op_valid_i && op_ready_o;
  assign is_read = take && (op_kind_i == BCDRS_OP_READ);
  assign is_write = take && (op_kind_i == BCDRS_OP_WRITE);
  assign is_arm = take && (op_kind_i == BCDRS_OP_ARM);
  assign is_xfer = take && (op_kind_i == BCDRS_OP_XFER);

  // ----------------------------------------
  // Decode and answer
  // ----------------------------------------
  assign hsk_status = {dir_a_q, dir_b_q, request_line_chan_a, request_line_chan_b, flag_a_i, flag_b_i, 2'b00};

  always_comb begin
    ans_err_d = `BCDRS_ERR_NONE;
    ans_data_d = 8'h00;
    hsk_wr = 1'b0;
    mask_wr = 1'b0;
    bidir_wr = 1'b0;
    if (is_read) begin
      if (op_reg_i == `BCDRS_REG_ID) begin
        ans_data_d = {1'b0, ID_VALUE[6:0]};
      end else if (op_reg_i == `BCDRS_REG_CAUSE) begin
        ans_data_d = cause_q;
      end else if (op_reg_i == `BCDRS_REG_HSK) begin
        ans_data_d = hsk_status;
      end else if (is_bidir(op_reg_i)) begin
        ans_data_d = bidir_q[bidir_idx(op_reg_i)];
      end else begin
        ans_err_d = `BCDRS_ERR_NOREG;
      end
    end else if (is_write) begin
      if (op_reg_i == `BCDRS_REG_MASK) begin
        mask_wr = 1'b1;
      end else if (op_reg_i == `BCDRS_REG_HSK) begin
        if ((op_data_i[`BCDRS_BIT_DIR_A] || op_data_i[`BCDRS_BIT_DIR_B])
            && !config_switch_bank_i[`BCDRS_SW_OUT_EN]) begin
          ans_err_d = `BCDRS_ERR_DIR;
        end else if (aux_port_unavail_i && (op_data_i[3:0] != 4'h0)) begin
          ans_err_d = `BCDRS_ERR_AUX;
        end else begin
          hsk_wr = 1'b1;
        end
      end else if (is_bidir(op_reg_i)) begin
        bidir_wr = 1'b1;
      end else begin
        // Register 0 and anything past the last register
        ans_err_d = `BCDRS_ERR_NOREG;
      end
    end else if (is_arm) begin
      mask_wr = 1'b1;
    end else if (is_xfer) begin
      if (op_data_i[0] ? request_line_chan_b : request_line_chan_a) begin
        ans_err_d = `BCDRS_ERR_CTL;
      end
    end
  end

  bcdrs_buf2 #(
    .WIDTH(16)
  ) u_ans_buf (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(take),
    .in_data_i({ans_err_d, ans_data_d}),
    .in_ready_o(op_ready_o),
    .out_valid_o(ans_valid_o),
    .out_data_o({ans_err_o, ans_data_o}),
    .out_ready_i(ans_ready_i)
  );

  // ----------------------------------------
  // Direction and port 10
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dir_a_q <= 1'b0;
      dir_b_q <= 1'b0;
      port10_q <= 4'h0;
    end else if (hsk_wr) begin
      dir_a_q <= op_data_i[`BCDRS_BIT_DIR_A];
      dir_b_q <= op_data_i[`BCDRS_BIT_DIR_B];
      // Switch 8 is not consulted here
      port10_q <= op_data_i[3:0];
    end
  end

  bcdrs_hs u_hs_a (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(hsk_wr),
    .wr_val_i(op_data_i[`BCDRS_BIT_REQUEST_LINE_CHAN_A]),
    .lead_sense_i(bidir_q[4][`BCDRS_BIT_LEAD_A]),
    .flag_i(flag_a_i),
    .ctl_o(request_line_chan_a)
  );

  bcdrs_hs u_hs_b (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(hsk_wr),
    .wr_val_i(op_data_i[`BCDRS_BIT_REQUEST_LINE_CHAN_B]),
    .lead_sense_i(bidir_q[4][`BCDRS_BIT_LEAD_B]),
    .flag_i(flag_b_i),
    .ctl_o(request_line_chan_b)
  );

  // ----------------------------------------
  // Bidirectional configuration registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `BCDRS_BIDIR_COUNT; i++) begin
        bidir_q[i] <= `BCDRS_RST_ZERO;
      end
      bidir_q[0] <= `BCDRS_RST_MANT;
      bidir_q[1] <= `BCDRS_RST_EXP;
      bidir_q[2] <= `BCDRS_RST_FUNC;
    end else if (bidir_wr) begin
      bidir_q[bidir_idx(op_reg_i)] <= op_data_i;
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  // Channel bits interleave so bit 7 is B and bit 6 is A
  always_comb begin
    digit_vec = 8'h00;
    for (int i = 0; i < 4; i++) begin
      digit_vec[2*i] = func_strobe_a_i && func_msd_a_i[i];
      digit_vec[2*i+1] = func_strobe_b_i && func_msd_b_i[i];
    end
  end

  assign hit = digit_vec & mask_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mask_q <= `BCDRS_RST_ZERO;
    end else if (mask_wr) begin
      mask_q <= op_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      armed_q <= 1'b0;
      cause_q <= `BCDRS_RST_ZERO;
      intr_q <= 1'b0;
    end else begin
      if (mask_wr) begin
        armed_q <= 1'b1;
        cause_q <= 8'h00;
      end
      if (is_read && (op_reg_i == `BCDRS_REG_CAUSE)) begin
        intr_q <= 1'b0;
      end
      // A raise wins over a clear arriving in the same cycle
      if (armed_q && (hit != 8'h00)) begin
        cause_q <= hit;
        intr_q <= 1'b1;
        armed_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dir_a_o = dir_a_q;
  assign dir_b_o = dir_b_q;
  assign request_line_chan_a_o = request_line_chan_a;
  assign request_line_chan_b_o = request_line_chan_b;
  assign port10_o = port10_q;
  assign intr_o = intr_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_ID_READ: assert property (
    (is_read && op_reg_i == `BCDRS_REG_ID && !ans_valid_o)
    |=> ans_data_o[7] == 1'b0 && ans_err_o == `BCDRS_ERR_NONE)
    else $error("Identity read wrong");

  AST_STATUS_READ: assert property (
    (is_read && op_reg_i == `BCDRS_REG_HSK && !ans_valid_o)
    |=> ans_data_o[1:0] == 2'b00 && ans_data_o[7] == $past(dir_a_o)
    && ans_data_o[5] == $past(request_line_chan_a_o))
    else $error("Status register read wrong");

  AST_WREG0_REJECT: assert property (
    (is_write && op_reg_i == `BCDRS_REG_ID && !ans_valid_o)
    |=> ans_valid_o && ans_err_o == `BCDRS_ERR_NOREG)
    else $error("Write register 0 not rejected");

  AST_DIR_NEEDS_SWITCH: assert property (
    (is_write && op_reg_i == `BCDRS_REG_HSK && op_data_i[`BCDRS_BIT_DIR_A]
    && !config_switch_bank_i[`BCDRS_SW_OUT_EN])
    |=> dir_a_o == $past(dir_a_o) && port10_o == $past(port10_o))
    else $error("Direction changed without switch 8");

  AST_XFER_CTL_BUSY: assert property (
    (is_xfer && !op_data_i[0] && request_line_chan_a_o && !ans_valid_o)
    |=> ans_err_o == `BCDRS_ERR_CTL)
    else $error("Transfer not rejected with request line set");

  AST_AUX_BLOCKED: assert property (
    (is_write && op_reg_i == `BCDRS_REG_HSK && aux_port_unavail_i && op_data_i[3:0] != 4'h0)
    |=> port10_o == $past(port10_o))
    else $error("Port 10 driven while unavailable");

  AST_MASK_BY_ARM: assert property (
    (is_arm && !(armed_q && hit != 8'h00)) |=> mask_q == $past(op_data_i) && armed_q)
    else $error("Arm did not load mask");

  AST_BLOCK_AFTER_RAISE: assert property (
    (armed_q && hit != 8'h00) |=> intr_o && !armed_q && cause_q == $past(hit))
    else $error("Interrupt raise did not block and latch cause");

  AST_MANT_RESET: assert property (@(posedge core_clk_i)
    $fell(sys_rst_i) |-> bidir_q[0] == `BCDRS_RST_MANT)
    else $error("Mantissa count reset value wrong");

  COV_INTR: cover property (armed_q && hit != 8'h00);
  COV_BUF_FULL: cover property (ans_valid_o && !op_ready_o);
  COV_DIR_ERR: cover property (ans_valid_o && ans_err_o == `BCDRS_ERR_DIR);

endmodule

// ---- logic/bcdrs_defs.svh ----
// Register numbers, field positions, reset values and answer codes of the register set
`ifndef BCDRS_DEFS_SVH
`define BCDRS_DEFS_SVH

// ----------------------------------------
// Register numbers
// ----------------------------------------
`define BCDRS_REG_ID 4'h0
`define BCDRS_REG_CAUSE 4'h1
`define BCDRS_REG_MASK 4'h1
`define BCDRS_REG_HSK 4'h2
`define BCDRS_REG_MANT 4'h3
`define BCDRS_REG_EXP 4'h4
`define BCDRS_REG_FUNC 4'h5
`define BCDRS_REG_SENSE 4'h7
`define BCDRS_REG_BIDIR_LAST 4'h9
`define BCDRS_BIDIR_COUNT 7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BCDRS_BIT_DIR_A 7
`define BCDRS_BIT_DIR_B 6
`define BCDRS_BIT_REQUEST_LINE_CHAN_A 5
`define BCDRS_BIT_REQUEST_LINE_CHAN_B 4
`define BCDRS_BIT_FLAG_A 3
`define BCDRS_BIT_FLAG_B 2
`define BCDRS_SW_OUT_EN 7
`define BCDRS_BIT_LEAD_A 1
`define BCDRS_BIT_LEAD_B 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BCDRS_RST_ZERO 8'h00
`define BCDRS_RST_MANT 8'h08
`define BCDRS_RST_EXP 8'h01
`define BCDRS_RST_FUNC 8'h01

// ----------------------------------------
// Answer codes
// ----------------------------------------
`define BCDRS_ERR_NONE 8'h00
`define BCDRS_ERR_NOREG 8'h6f
`define BCDRS_ERR_DIR 8'h71
`define BCDRS_ERR_AUX 8'h72
`define BCDRS_ERR_CTL 8'h76

`endif

// ---- logic/bcdrs_pkg.sv ----
// Types shared by the register set modules
package bcdrs_pkg;

  typedef enum logic [1:0] {
    BCDRS_OP_READ,
    BCDRS_OP_WRITE,
    BCDRS_OP_ARM,
    BCDRS_OP_XFER
  } bcdrs_op_type;

endpackage

// ---- logic/bcdrs_buf2.sv ----
// Two-entry answer buffer with valid and ready on both sides
`timescale 1ns/10ps
module bcdrs_buf2 import bcdrs_pkg::*; #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] tail_q;
  logic head_v_q;
  logic tail_v_q;
  logic ready_q;
  logic push;
  logic pop;
  logic tail_v_d;

  assign push = in_valid_i && ready_q;
  assign pop = head_v_q && out_ready_i;

  always_comb begin
    if (pop) begin
      tail_v_d = tail_v_q && push;
    end else begin
      tail_v_d = tail_v_q || (head_v_q && push);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
      ready_q <= 1'b1;
      head_q <= '0;
      tail_q <= '0;
    end else begin
      tail_v_q <= tail_v_d;
      // Ready is registered so the filler never sees a combinational path
      ready_q <= !tail_v_d;
      if (pop) begin
        if (tail_v_q) begin
          head_q <= tail_q;
          if (push) begin
            tail_q <= in_data_i;
          end
        end else begin
          head_v_q <= push;
          head_q <= in_data_i;
        end
      end else if (!head_v_q) begin
        head_v_q <= push;
        head_q <= in_data_i;
      end else if (push) begin
        tail_q <= in_data_i;
      end
    end
  end

  assign in_ready_o = ready_q;
  assign out_valid_o = head_v_q;
  assign out_data_o = head_q;

  AST_BUF_FULL_STALLS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (head_v_q && tail_v_q) |-> !ready_q)
    else $error("Buffer full but still ready");

endmodule

// ---- logic/bcdrs_hs.sv ----
// One channel's request line with flag edge release
`timescale 1ns/10ps
module bcdrs_hs import bcdrs_pkg::*; (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Software control
  input wire logic wr_en_i,
  input wire logic wr_val_i,
  input wire logic lead_sense_i,
  // Peripheral side
  input wire logic flag_i,
  output logic ctl_o
);

  logic flag_q;
  logic ctl_q;
  logic release_edge;

  // Leading edge is flag going busy, trailing edge is flag going ready
  assign release_edge = lead_sense_i ? (flag_i && !flag_q) : (!flag_i && flag_q);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ctl_q <= 1'b0;
    end else if (wr_en_i) begin
      // Software write wins over a release in the same cycle
      ctl_q <= wr_val_i;
    end else if (release_edge) begin
      ctl_q <= 1'b0;
    end
  end

  assign ctl_o = ctl_q;

  AST_CTL_RELEASE_ON_EDGE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(ctl_q) |-> $past(wr_en_i) || ($past(lead_sense_i) ? $rose(flag_q)
    : $fell(flag_q)))
    else $error("Request line dropped without write or flag edge");

endmodule

// ---- verification/bcdrs_instr.sv ----
// Behavioural model of one BCD instrument with flag handshake
`timescale 1ns/10ps
module bcdrs_instr import bcdrs_pkg::*; (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Bench control
  input wire logic [7:0] dly_i,
  input wire logic [3:0] digit_i,
  // Interface side
  input wire logic ctl_i,
  output logic flag_o,
  output logic strobe_o,
  output logic [3:0] msd_o
);
  logic ctl_q;
  logic [1:0] ph_q;
  logic [7:0] cnt_q;

  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ctl_q <= 1'b0;
      ph_q <= 2'h0;
      cnt_q <= 8'h00;
      flag_o <= 1'b0;
      strobe_o <= 1'b0;
      msd_o <= 4'h0;
    end else begin
      ctl_q <= ctl_i;
      strobe_o <= 1'b0;
      // Digit lines are only meaningful with the strobe
      msd_o <= ~msd_o;
      case (ph_q)
        2'h0: begin
          if (ctl_i && !ctl_q) begin
            ph_q <= 2'h1;
            cnt_q <= dly_i;
          end
        end
        2'h1: begin
          if (cnt_q == 8'h00) begin
            flag_o <= 1'b1;
            ph_q <= 2'h2;
            cnt_q <= dly_i;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          if (cnt_q == 8'h00) begin
            flag_o <= 1'b0;
            strobe_o <= 1'b1;
            msd_o <= digit_i;
            ph_q <= 2'h0;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
      endcase
    end
  end
endmodule

// ---- verification/test_bcdrs_top.sv ----
// Self-checking bench for the register set
`timescale 1ns/10ps
module test_bcdrs_top import bcdrs_pkg::*;;
  logic core_clk_i, sys_rst_i, op_valid, op_ready, ans_valid, ans_ready, aux;
  logic flag_a, flag_b, stb_a, stb_b, dir_a, dir_b, request_line_chan_a, request_line_chan_b, intr;
  bcdrs_op_type op_kind;
  logic [3:0] op_reg, msd_a, msd_b, port10, dig_a, dig_b;
  logic [7:0] op_data, ans_err, ans_data, sw, dly_a, dly_b;
  int miscompares, n_compared, cyc;

  bcdrs_top #(.ID_VALUE(8'hc3)) bcdrs_top_inst (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .op_valid_i(op_valid), .op_kind_i(op_kind), .op_reg_i(op_reg),
    .op_data_i(op_data), .op_ready_o(op_ready), .ans_valid_o(ans_valid),
    .ans_err_o(ans_err), .ans_data_o(ans_data), .ans_ready_i(ans_ready),
    .config_switch_bank_i(sw), .aux_port_unavail_i(aux), .flag_a_i(flag_a),
    .flag_b_i(flag_b), .func_strobe_a_i(stb_a), .func_msd_a_i(msd_a),
    .func_strobe_b_i(stb_b), .func_msd_b_i(msd_b), .dir_a_o(dir_a), .dir_b_o(dir_b),
    .request_line_chan_a_o(request_line_chan_a), .request_line_chan_b_o(request_line_chan_b), .port10_o(port10),
    .intr_o(intr));
  bcdrs_instr bcdrs_instr_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .dly_i(dly_a), .digit_i(dig_a), .ctl_i(request_line_chan_a), .flag_o(flag_a), .strobe_o(stb_a),
    .msd_o(msd_a));
  bcdrs_instr bcdrs_instr_b_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .dly_i(dly_b), .digit_i(dig_b), .ctl_i(request_line_chan_b), .flag_o(flag_b), .strobe_o(stb_b),
    .msd_o(msd_b));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_lvl(input string nm, ref logic s, input logic v, input int mx);
    int n;
    n = 0;
    while (s !== v && n < mx) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(nm, {7'h00, v}, {7'h00, s});
  endtask

  task automatic send(input bcdrs_op_type k, input logic [3:0] r, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge core_clk_i);
    op_valid = 1'b1;
    op_kind = k;
    op_reg = r;
    op_data = d;
    // Ready is registered, so its level at the falling edge decides the next take
    while (op_ready !== 1'b1 && n < 100) begin
      n++;
      @(negedge core_clk_i);
    end
    chk("op_ready", 8'h01, {7'h00, op_ready});
    @(negedge core_clk_i);
    op_valid = 1'b0;
  endtask

  task automatic take(input logic [7:0] ee, input logic [7:0] ed);
    wait_lvl("ans_valid", ans_valid, 1'b1, 100);
    chk("ans_err", ee, ans_err);
    chk("ans_data", ed, ans_data);
    ans_ready = 1'b1;
    @(negedge core_clk_i);
    ans_ready = 1'b0;
  endtask

  task automatic op(bcdrs_op_type k, logic [3:0] r, logic [7:0] d, logic [7:0] ee,
                    logic [7:0] ed);
    send(k, r, d);
    take(ee, ed);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("outs", 8'h00, {3'h0, dir_a, dir_b, request_line_chan_a, request_line_chan_b, intr});
    chk("port10", 8'h00, {4'h0, port10});
    chk("op_ready", 8'h01, {7'h00, op_ready});
    op(BCDRS_OP_READ, 4'h0, 8'h00, 8'h00, 8'h43);
    op(BCDRS_OP_WRITE, 4'h0, 8'h11, 8'h6f, 8'h00);
    op(BCDRS_OP_READ, 4'h0, 8'h00, 8'h00, 8'h43);
    op(BCDRS_OP_READ, 4'h1, 8'h00, 8'h00, 8'h00);
    op(BCDRS_OP_READ, 4'h2, 8'h00, 8'h00, 8'h00);
    op(BCDRS_OP_READ, 4'h3, 8'h00, 8'h00, 8'h08);
    op(BCDRS_OP_READ, 4'ha, 8'h00, 8'h6f, 8'h00);
    op(BCDRS_OP_WRITE, 4'h3, 8'h44, 8'h00, 8'h00);
    op(BCDRS_OP_READ, 4'h3, 8'h00, 8'h00, 8'h44);
    op(BCDRS_OP_WRITE, 4'h9, 8'ha5, 8'h00, 8'h00);
    op(BCDRS_OP_READ, 4'h9, 8'h00, 8'h00, 8'ha5);
  endtask

  task automatic t_dir_port();
    op(BCDRS_OP_WRITE, 4'h2, 8'h83, 8'h71, 8'h00);
    chk("dir_port", 8'h00, {dir_a, 3'h0, port10});
    sw = 8'h80;
    op(BCDRS_OP_WRITE, 4'h2, 8'hc3, 8'h00, 8'h00);
    chk("dir_port", 8'hc3, {dir_a, dir_b, 2'h0, port10});
    op(BCDRS_OP_READ, 4'h2, 8'h00, 8'h00, 8'hc0);
    aux = 1'b1;
    op(BCDRS_OP_WRITE, 4'h2, 8'h05, 8'h72, 8'h00);
    chk("dir_port", 8'hc3, {dir_a, dir_b, 2'h0, port10});
    op(BCDRS_OP_WRITE, 4'h2, 8'h00, 8'h00, 8'h00);
    chk("dir", 8'h00, {6'h00, dir_a, dir_b});
  endtask

  task automatic t_buffer();
    // Two answers held back while the consumer stalls
    send(BCDRS_OP_READ, 4'h0, 8'h00);
    send(BCDRS_OP_READ, 4'h3, 8'h00);
    chk("op_ready", 8'h00, {7'h00, op_ready});
    take(8'h00, 8'h43);
    take(8'h00, 8'h44);
    chk("op_ready", 8'h01, {7'h00, op_ready});
  endtask

  task automatic t_ctl(input logic [7:0] sense);
    op(BCDRS_OP_WRITE, 4'h7, sense, 8'h00, 8'h00);
    op(BCDRS_OP_WRITE, 4'h2, 8'h20, 8'h00, 8'h00);
    chk("ctl", 8'h02, {6'h00, request_line_chan_a, request_line_chan_b});
    op(BCDRS_OP_XFER, 4'h0, 8'h00, 8'h76, 8'h00);
    op(BCDRS_OP_XFER, 4'h0, 8'h01, 8'h00, 8'h00);
    wait_lvl("flag_a", flag_a, 1'b1, 100);
    if (sense == 8'h00) begin
      op(BCDRS_OP_READ, 4'h2, 8'h00, 8'h00, 8'h28);
      wait_lvl("flag_a", flag_a, 1'b0, 100);
    end
    chk("request_line_chan_a", 8'h01, {7'h00, request_line_chan_a});
    wait_lvl("request_line_chan_a", request_line_chan_a, 1'b0, 2);
    wait_lvl("flag_a", flag_a, 1'b0, 100);
    op(BCDRS_OP_WRITE, 4'h7, 8'h00, 8'h00, 8'h00);
  endtask

  task automatic t_request_line_chan_b();
    // Leading edge sense on channel B
    op(BCDRS_OP_WRITE, 4'h7, 8'h01, 8'h00, 8'h00);
    op(BCDRS_OP_WRITE, 4'h2, 8'h10, 8'h00, 8'h00);
    wait_lvl("flag_b", flag_b, 1'b1, 20);
    chk("request_line_chan_b", 8'h01, {7'h00, request_line_chan_b});
    wait_lvl("request_line_chan_b", request_line_chan_b, 1'b0, 2);
    wait_lvl("flag_b", flag_b, 1'b0, 20);
    op(BCDRS_OP_WRITE, 4'h7, 8'h00, 8'h00, 8'h00);
  endtask

  task automatic t_intr();
    op(BCDRS_OP_ARM, 4'h0, 8'h80, 8'h00, 8'h00);
    dig_b = 4'h8;
    op(BCDRS_OP_WRITE, 4'h2, 8'h10, 8'h00, 8'h00);
    wait_lvl("intr", intr, 1'b1, 60);
    op(BCDRS_OP_READ, 4'h1, 8'h00, 8'h00, 8'h80);
    chk("intr", 8'h00, {7'h00, intr});
    op(BCDRS_OP_WRITE, 4'h2, 8'h10, 8'h00, 8'h00);
    wait_lvl("request_line_chan_b", request_line_chan_b, 1'b0, 60);
    repeat (2) @(negedge core_clk_i);
    chk("intr", 8'h00, {7'h00, intr});
    op(BCDRS_OP_READ, 4'h1, 8'h00, 8'h00, 8'h80);
    op(BCDRS_OP_WRITE, 4'h1, 8'h01, 8'h00, 8'h00);
    op(BCDRS_OP_READ, 4'h1, 8'h00, 8'h00, 8'h00);
    dig_a = 4'h2;
    op(BCDRS_OP_WRITE, 4'h2, 8'h20, 8'h00, 8'h00);
    wait_lvl("request_line_chan_a", request_line_chan_a, 1'b0, 60);
    repeat (2) @(negedge core_clk_i);
    chk("intr", 8'h00, {7'h00, intr});
    dig_a = 4'h1;
    op(BCDRS_OP_WRITE, 4'h2, 8'h20, 8'h00, 8'h00);
    wait_lvl("intr", intr, 1'b1, 60);
    op(BCDRS_OP_READ, 4'h1, 8'h00, 8'h00, 8'h01);
  endtask

  // ----------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    miscompares = 0;
    n_compared = 0;
    cyc = 0;
    sys_rst_i = 1'b1;
    op_valid = 1'b0;
    op_kind = BCDRS_OP_READ;
    op_reg = 4'h0;
    op_data = 8'h00;
    ans_ready = 1'b0;
    sw = 8'h00;
    aux = 1'b0;
    dly_a = 8'h14;
    dly_b = 8'h02;
    dig_a = 4'h0;
    dig_b = 4'h0;
    repeat (12) @(posedge core_clk_i);
    @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_dir_port();
    t_buffer();
    t_ctl(8'h00);
    t_ctl(8'h02);
    t_request_line_chan_b();
    t_intr();
    end_sim();
  end
endmodule
